// ===== dv/adc_source_model.sv
`timescale 1ns/1ns
module adc_source_model
  import sample_fifo_pkg::*;
(
  input wire logic                   mclk,
  output logic [NUM_CH-1:0]          sample_valid,
  output logic [NUM_CH*SAMPLE_W-1:0] sample_value
);
  initial begin
    sample_valid = '0;
    sample_value = '1;
  end
  // One-cycle strobe, value scrambled once it is gone
  task automatic push(input int ch, input logic [SAMPLE_W-1:0] v);
    sample_valid[ch] <= 1'b1;
    sample_value[ch*SAMPLE_W +: SAMPLE_W] <= v;
    @(posedge mclk);
    sample_valid[ch] <= 1'b0;
    sample_value <= ~sample_value;
    @(posedge mclk);
  endtask : push
endmodule : adc_source_model

// ===== dv/sample_readout_props.sv
`timescale 1ns/1ns
module sample_readout_props
  import sample_fifo_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [7:0] rd_addr;
  wire        is_data = rd_addr inside {8'h74, 8'h7c, 8'h84, 8'h8c};
  wire        is_lvl  = rd_addr inside {8'h94, 8'h9c, 8'ha4, 8'hac};
  wire        is_map  = is_data || is_lvl || rd_addr inside {8'h6c, 8'h70};
  // Address of the read in flight
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_stall; s_axi_rvalid && !s_axi_rready; endsequence
  a_rd_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_rd_hold: assert property (rd_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  a_data_reserved: assert property (
    s_axi_rvalid && is_data |-> s_axi_rdata[31] == 1'b0 && s_axi_rdata[1:0] == 2'h0)
    else $error("reserved data bits set");
  a_level_range: assert property (
    s_axi_rvalid && is_lvl |-> s_axi_rdata[31:3] == 29'h0 && s_axi_rdata[2:0] <= 3'h4)
    else $error("level out of range");
  a_data_okay: assert property (
    s_axi_rvalid && (is_data || is_lvl) |-> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_unmapped_err: assert property (
    s_axi_rvalid && !is_map |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : sample_readout_props

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import sample_fifo_pkg::*;
;
  logic                       mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic                       s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [NUM_CH-1:0]          sample_valid, sample_ready;
  logic [NUM_CH*SAMPLE_W-1:0] sample_value;
  logic [7:0]                 s_axi_awaddr, s_axi_araddr;
  logic [31:0]                s_axi_wdata, s_axi_rdata;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp, s_axi_rresp;
  logic [65:0]                q[$];
  logic [SAMPLE_W-1:0]        smp[5];
  int                         fails, cmp_count, cycles;
  int                         seed = 32'hd4d3;
  sample_readout u_sample_readout (.*);
  adc_source_model u_adc_source_model (.mclk(mclk), .sample_valid(sample_valid),
                                       .sample_value(sample_value));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    q.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    q.push_back({r, 64'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) aw_done = 1'b1;
      if (s_axi_wready === 1'b1) w_done = 1'b1;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // Scoreboard: oldest note against each answer
  always @(posedge mclk) begin
    logic [65:0] e;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk("rdata", e[31:0], s_axi_rdata & e[63:32]);
      chk("rresp", 32'(e[65:64]), 32'(s_axi_rresp));
      if (!e[46]) chk("stamp", 32'h1, 32'(s_axi_rdata[30:14] <= 17'h3));
    end
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      chk("bresp", 32'(e[65:64]), 32'(s_axi_bresp));
    end
  end
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {fails, cmp_count, cycles} = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int c = 0; c < 4; c++) rd(8'(8'h94 + 8 * c), 32'h0, '1, RESP_OKAY);
    rd(8'h8c, 32'h0, '1, RESP_OKAY);
    rd(8'hf0, 32'h0, '1, RESP_SLVERR);
    wr(8'h94, 32'h0000_0007, RESP_SLVERR);
    rd(8'h94, 32'h0, '1, RESP_OKAY);
    rd(8'h6c, 32'h0011_1111, '1, RESP_OKAY);
    wr(8'h6c, 32'h02fe_0003, RESP_OKAY);
    rd(8'h6c, 32'h02fe_0003, '1, RESP_OKAY);
    $display("test reset and map done");
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 5; i++) begin
        smp[i] = SAMPLE_W'($random(seed));
        u_adc_source_model.push(c, smp[i]);
      end
      repeat (2) @(posedge mclk);
      chk("ready", 32'h0, 32'(sample_ready[c]));
      rd(8'(8'h94 + 8 * c), 32'h4, '1, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
        rd(8'(8'h74 + 8 * c), {1'b0, 17'h0, smp[i], 2'h0}, 32'h8000_3fff, RESP_OKAY);
        if (i == 1) rd(8'(8'h94 + 8 * c), 32'h2, '1, RESP_OKAY);
      end
      rd(8'(8'h94 + 8 * c), 32'h0, '1, RESP_OKAY);
      chk("ready", 32'h1, 32'(sample_ready[c]));
      $display("test channel %0d done", c);
    end
    wr(8'h6c, 32'h0100_0003, RESP_OKAY);
    rd(8'h70, 32'h0, '1, RESP_OKAY);
    $display("test timestamp clear done");
    print_verdict();
  end
endmodule : tb_top
bind sample_readout sample_readout_props u_sample_readout_props (.*);

// ===== src/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo
  import sample_fifo_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               push,
  input  wire logic [WIDTH-1:0]   push_data,
  output logic                    push_ready,
  input  wire logic               pop,
  output logic [WIDTH-1:0]        pop_data,
  output logic [LEVEL_W-1:0]      level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  wire              full      = (level == LEVEL_W'(DEPTH));
  wire              empty     = (level == '0);
  wire              do_push   = push && !full;
  wire              do_pop    = pop && !empty;

  assign push_ready = !full;
  assign pop_data   = mem[rd_ptr];

  // Cleared so an empty read after reset gives the zero reset value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Level bounded by full and empty guards
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) wr_ptr <= PTR_W'(wr_ptr + 1'b1);
      if (do_pop) rd_ptr <= PTR_W'(rd_ptr + 1'b1);
      level <= LEVEL_W'(level + {2'b00, do_push} - {2'b00, do_pop});
    end
  end

endmodule : sample_fifo

// ===== src/sample_fifo_pkg.sv
package sample_fifo_pkg;

  localparam int          NUM_CH       = 4;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          LEVEL_W      = 3;
  localparam int          SAMPLE_W     = 12;
  localparam int          STAMP_W      = 17;
  localparam int          PERIOD_W     = 24;

  localparam int          SAMPLE_LSB   = 2;
  localparam int          SAMPLE_MSB   = 13;
  localparam int          STAMP_LSB    = 14;
  localparam int          STAMP_MSB    = 30;

  // Byte offsets
  localparam logic [7:0]  CH0_DATA_OFF = 8'h74;
  localparam logic [7:0]  CH2_DATA_OFF = 8'h7c;
  localparam logic [7:0]  CH4_DATA_OFF = 8'h84;
  localparam logic [7:0]  CH6_DATA_OFF = 8'h8c;
  localparam logic [7:0]  CH0_LVL_OFF  = 8'h94;
  localparam logic [7:0]  CH2_LVL_OFF  = 8'h9c;
  localparam logic [7:0]  CH4_LVL_OFF  = 8'ha4;
  localparam logic [7:0]  CH6_LVL_OFF  = 8'hac;
  localparam logic [7:0]  STAMP_CFG_OFF = 8'h6c;
  localparam logic [7:0]  STAMP_CUR_OFF = 8'h70;

  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [23:0] PERIOD_RESET = 24'h11_1111;
  localparam int          CFG_EN_BIT   = 25;
  localparam int          CFG_CLR_BIT  = 24;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_t;

endpackage : sample_fifo_pkg

// ===== src/sample_readout.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module sample_readout
  import sample_fifo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  // Converter side, one strobe per channel
  input  wire logic [NUM_CH-1:0]             sample_valid,
  input  wire logic [NUM_CH*SAMPLE_W-1:0]    sample_value,
  output logic [NUM_CH-1:0]                  sample_ready,
  // AXI4-Lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  // --------------------------------------------------
  // Timestamp counter
  // --------------------------------------------------
  logic [PERIOD_W-1:0] timestamp_period;
  logic                stamp_enable;
  logic                stamp_clear;
  logic [STAMP_W-1:0]  stamp_count;
  wire  [STAMP_W-1:0]  period_low = timestamp_period[STAMP_W-1:0];
  wire                 stamp_wrap = (stamp_count >= period_low);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stamp_count <= '0;
    end else if (stamp_clear || (stamp_enable && stamp_wrap)) begin
      stamp_count <= '0;
    end else if (stamp_enable) begin
      stamp_count <= STAMP_W'(stamp_count + 1'b1);
    end
  end

  // --------------------------------------------------
  // Channel FIFOs
  // --------------------------------------------------
  logic [NUM_CH-1:0]   pop_ch;
  logic [31:0]         fifo_word [NUM_CH];
  logic [LEVEL_W-1:0]  fifo_level [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire [31:0] packed_word = {1'b0, stamp_count,
                                 sample_value[g*SAMPLE_W +: SAMPLE_W], 2'b00};
      sample_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH)
      ) u_fifo (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .push       (sample_valid[g]),
        .push_data  (packed_word),
        .push_ready (),
        .pop        (pop_ch[g]),
        .pop_data   (fifo_word[g]),
        .level      (fifo_level[g])
      );
      // Ready drops early so a strobe in flight still fits
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sample_ready[g] <= 1'b0;
        end else begin
          sample_ready[g] <= (fifo_level[g] < LEVEL_W'(DEPTH - 1)) ||
                             ((fifo_level[g] == LEVEL_W'(DEPTH - 1)) && !sample_valid[g]);
        end
      end
    end
  endgenerate

  // --------------------------------------------------
  // Read decode
  // --------------------------------------------------
  function automatic logic [2:0] decode_ch(input logic [7:0] addr, input logic data_sel);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    decode_ch = 3'b100;
    if (data_sel) begin
      if (a == CH0_DATA_OFF) decode_ch = 3'd0;
      if (a == CH2_DATA_OFF) decode_ch = 3'd1;
      if (a == CH4_DATA_OFF) decode_ch = 3'd2;
      if (a == CH6_DATA_OFF) decode_ch = 3'd3;
    end else begin
      if (a == CH0_LVL_OFF) decode_ch = 3'd0;
      if (a == CH2_LVL_OFF) decode_ch = 3'd1;
      if (a == CH4_LVL_OFF) decode_ch = 3'd2;
      if (a == CH6_LVL_OFF) decode_ch = 3'd3;
    end
  endfunction : decode_ch

  wire [7:0]  rd_addr   = {s_axi_araddr[7:2], 2'b00};
  wire [2:0]  data_hit  = decode_ch(s_axi_araddr, 1'b1);
  wire [2:0]  lvl_hit   = decode_ch(s_axi_araddr, 1'b0);
  wire        is_data   = !data_hit[2];
  wire        is_lvl    = !lvl_hit[2];
  wire        is_cfg    = (rd_addr == STAMP_CFG_OFF);
  wire        is_cur    = (rd_addr == STAMP_CUR_OFF);
  wire        rd_take   = s_axi_arvalid && s_axi_arready;
  wire [31:0] cfg_word  = {6'b0, stamp_enable, 1'b0, timestamp_period};

  // Popping on an empty FIFO is blocked inside the FIFO
  assign pop_ch = (rd_take && is_data) ? (NUM_CH'(1) << data_hit[1:0]) : '0;

  // Empty FIFO returns its stale entry
  wire [31:0] next_rdata =
      is_data ? fifo_word[data_hit[1:0]] :
      is_lvl  ? {29'b0, fifo_level[lvl_hit[1:0]]} :
      is_cfg  ? cfg_word :
      is_cur  ? {15'b0, stamp_count} : ZERO_WORD;
  wire        rd_ok   = is_data || is_lvl || is_cfg || is_cur;

  // --------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------
  // Answer stands until rready
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // --------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------
  // Write fires once both halves are held or taken
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire  aw_take  = s_axi_awvalid && s_axi_awready;
  wire  w_take   = s_axi_wvalid && s_axi_wready;
  wire  aw_have  = aw_held || aw_take;
  wire  w_have   = w_held || w_take;
  wire  [7:0]  wa = aw_take ? {s_axi_awaddr[7:2], 2'b00} : aw_addr;
  wire  [31:0] wd = w_take ? s_axi_wdata : w_data;
  wire  [3:0]  ws = w_take ? s_axi_wstrb : w_strb;
  wire  wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire  wr_cfg   = wr_fire && (wa == STAMP_CFG_OFF);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= ZERO_WORD;
      w_strb  <= '0;
    end else begin
      aw_held <= aw_have && !wr_fire;
      w_held  <= w_have && !wr_fire;
      if (aw_take) aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      if (w_take) w_data <= s_axi_wdata;
      if (w_take) w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= (wa == STAMP_CFG_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have;
      s_axi_wready  <= !w_have;
    end
  end

  // Timestamp configuration, byte enables honoured
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timestamp_period <= PERIOD_RESET;
      stamp_enable     <= 1'b0;
      stamp_clear      <= 1'b0;
    end else begin
      stamp_clear <= wr_cfg && ws[3] && wd[CFG_CLR_BIT];
      if (wr_cfg && ws[3]) stamp_enable <= wd[CFG_EN_BIT];
      if (wr_cfg && ws[0]) timestamp_period[7:0] <= wd[7:0];
      if (wr_cfg && ws[1]) timestamp_period[15:8] <= wd[15:8];
      if (wr_cfg && ws[2]) timestamp_period[23:16] <= wd[23:16];
    end
  end

endmodule : sample_readout
